// >>> logic/i2cmt_bit_timer.sv
// bit timer: counts half bit periods and pulses when one has elapsed.
// held at zero while clear_i is high, which is how idle, hold and waiting on a busy bus freeze it.
`timescale 1ns/10ps
`default_nettype none
module i2cmt_bit_timer
   import i2cmt_pkg::*;
#(
   parameter int HALF_CYCLES = HALF_BIT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clear_i,
   output logic tick_o
);
   typedef struct packed {
      logic [15:0] count;
      logic tick;
   } i2cmt_tmr_type;
   i2cmt_tmr_type r;
   i2cmt_tmr_type next_r;

   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      if (clear_i) begin
         next_r.count = 16'h0000;
      end else if (r.count == 16'(HALF_CYCLES - 1)) begin
         next_r.count = 16'h0000;
         next_r.tick = 1'b1;
      end else begin
         next_r.count = r.count + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick_o = r.tick;
endmodule
`default_nettype wire

// >>> logic/i2cmt_bus_monitor.sv
// bus monitor: two-flop synchronises both lines and tracks START/STOP to
// tell whether the bus is owned by anyone. assumes raw pin levels as inputs.
`timescale 1ns/10ps
`default_nettype none
module i2cmt_bus_monitor
   import i2cmt_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   i2cmt_line_if.mon line
);
   typedef struct packed {
      logic [1:0] scl_meta;
      logic [1:0] sda_meta;
      logic scl_prev;
      logic sda_prev;
      logic busy;
   } i2cmt_mon_type;
   i2cmt_mon_type r;
   i2cmt_mon_type next_r;

   always_comb begin
      next_r = r;
      next_r.scl_meta = {r.scl_meta[0], scl_i};
      next_r.sda_meta = {r.sda_meta[0], sda_i};
      next_r.scl_prev = r.scl_meta[1];
      next_r.sda_prev = r.sda_meta[1];
      // sda falling with scl high is a start, rising is a stop
      if (r.scl_meta[1] && r.scl_prev && r.sda_prev && !r.sda_meta[1]) begin
         next_r.busy = 1'b1;
      end else if (r.scl_meta[1] && r.scl_prev && !r.sda_prev && r.sda_meta[1]) begin
         next_r.busy = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1, busy: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign line.scl = r.scl_meta[1];
   assign line.sda = r.sda_meta[1];
   assign line.bus_busy = r.busy;
endmodule
`default_nettype wire

// >>> logic/i2cmt_ctrl.sv
// top: two-wire controller-transmitter with control, status and data registers
// on a plain port. assumes open-drain pins resolved outside; oe high drives low.
`timescale 1ns/10ps
`default_nettype none
//
// Function
// [R1] software keeps enable set; cleared enable produces no bus activity
// [R2] software starts with done=1, start=1, stop=0, enable=1
// [R3] start request waits for idle bus before driving START
// [R4] after START, set done flag and report 0x08
// [R5] software loads address-write then clears flag with start/stop zero
// [R6] writing one clears done flag and resumes; zero leaves it
// [R7] after address byte report 0x18 ack, 0x20 nack, 0x38 lost
// [R8] software writes data register only while done flag is high
// [R9] data write while flag low is dropped and sets write collision
// [R10] after data byte report 0x28 ack or 0x30 nack
// [R11] continuing in 0x18..0x30 sends loaded byte and samples acknowledge
// [R12] software ends with done=1, start=0, stop=1, enable=1
// [R13] clearing with stop sends STOP and self-clears stop request
// [R14] software requests repeated start with start=1, stop=0
// [R15] clearing with start during owned transfer sends repeated START
// [R16] after repeated START report 0x10 and keep bus ownership
// [R17] in 0x10 the loaded address is sent; read bit enters receive mode
// [R18] clearing with start and stop sends STOP, then START, clears stop
// [R19] arbitration loss in address or data byte reports 0x38 with flag
// [R20] in 0x38 continuing without start releases bus, not addressed
// [R21] in 0x38 continuing with start waits for free bus, then START
// [R22] status codes assume prescaler bits zero; software masks them
// [R23] while done flag set the transfer stays suspended, scl held low; code releases scl in 0x38
// [R24] done flag with interrupt enable raises request until cleared
module i2cmt_ctrl
   import i2cmt_pkg::*;
#(
   parameter int HALF_CYCLES = HALF_BIT_CYCLES
)
(
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   input wire logic [1:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE_O,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   output logic RECEIVE_MODE_O,
   output logic IRQ_O
);
   typedef enum logic [3:0] {
      S_IDLE, S_WAIT_FREE, S_START_A, S_START_B, S_HOLD,
      S_BIT_LOW, S_BIT_HIGH, S_STOP_A, S_STOP_B, S_STOP_C, S_RS_A
   } i2cmt_state_type;

   typedef struct packed {
      i2cmt_state_type state;
      logic [7:0] control;
      logic [7:0] status;
      logic [7:0] data;
      logic [7:0] shift;
      logic [3:0] bit_cnt;
      logic addr_phase;
      logic restart_after_stop;
      logic owned;
      logic scl_oe;
      logic sda_oe;
      logic [7:0] rdata;
      logic rx_mode;
      logic irq;
   } i2cmt_reg_type;

   i2cmt_reg_type r;
   i2cmt_reg_type next_r;
   i2cmt_line_if line ();
   logic tick;
   logic timer_clear;

   i2cmt_bus_monitor u_mon (
      .clk_i(CLK_SYS_I),
      .reset_n_i(RESET_N_I),
      .scl_i(SCL_I),
      .sda_i(SDA_I),
      .line(line)
   );

   i2cmt_bit_timer #(.HALF_CYCLES(HALF_CYCLES)) u_tmr (
      .clk_i(CLK_SYS_I),
      .reset_n_i(RESET_N_I),
      .clear_i(timer_clear),
      .tick_o(tick)
   );

   // timer frozen while parked or idle so each phase starts a full half bit
   assign timer_clear = (r.state == S_IDLE) || (r.state == S_HOLD) ||
                        (r.state == S_WAIT_FREE && line.bus_busy && !r.owned);

   function automatic logic [7:0] rd_mux(input logic [1:0] a, input i2cmt_reg_type s);
      unique case (a)
         ADDR_CONTROL: rd_mux = s.control;
         ADDR_STATUS: rd_mux = s.status;
         ADDR_DATA: rd_mux = s.data;
         default: rd_mux = 8'h00;
      endcase
   endfunction

   always_comb begin
      next_r = r;
      next_r.rdata = RD_I ? rd_mux(ADDR_I, r) : 8'h00;
      // ----------------------------------------------------------------
      // register writes
      // ----------------------------------------------------------------
      if (WR_I && ADDR_I == ADDR_CONTROL) begin
         next_r.control[CTL_ACKEN] = WDATA_I[CTL_ACKEN];
         next_r.control[CTL_START] = WDATA_I[CTL_START];
         next_r.control[CTL_STOP] = WDATA_I[CTL_STOP];
         next_r.control[CTL_ENABLE] = WDATA_I[CTL_ENABLE];
         next_r.control[CTL_IRQEN] = WDATA_I[CTL_IRQEN];
         // [R6] write one clears
         if (WDATA_I[CTL_DONE]) begin
            next_r.control[CTL_DONE] = 1'b0;
         end
         if (!WDATA_I[CTL_WCOL] && r.control[CTL_WCOL]) begin
            next_r.control[CTL_WCOL] = 1'b0;
         end
      end
      if (WR_I && ADDR_I == ADDR_DATA) begin
         // [R9] collision drop
         if (r.control[CTL_DONE]) begin
            next_r.data = WDATA_I;
         end else begin
            next_r.control[CTL_WCOL] = 1'b1;
         end
      end
      // ----------------------------------------------------------------
      // bus sequencer
      // ----------------------------------------------------------------
      unique case (r.state)
         S_IDLE: begin
            // [R1] enable gates activity
            if (r.control[CTL_ENABLE] && r.control[CTL_START] && !r.control[CTL_DONE]) begin
               next_r.state = S_WAIT_FREE;
            end
         end
         S_WAIT_FREE: begin
            // [R3] wait for idle bus; an owned bus is busy only because of our own start
            if ((!line.bus_busy || r.owned) && tick) begin
               next_r.sda_oe = 1'b1;
               next_r.state = S_START_A;
            end
         end
         S_START_A: begin
            if (tick) begin
               next_r.scl_oe = 1'b1;
               next_r.owned = 1'b1;
               next_r.state = S_START_B;
            end
         end
         S_START_B: begin
            // [R4] start done, 0x08; [R16] repeated start 0x10
            next_r.status = r.owned && r.restart_after_stop ? ST_RSTART : ST_START;
            next_r.status = (r.status == ST_IDLE || r.status == ST_ARB_LOST) ? ST_START : next_r.status;
            next_r.restart_after_stop = 1'b0;
            next_r.control[CTL_DONE] = 1'b1;
            next_r.addr_phase = 1'b1;
            next_r.state = S_HOLD;
         end
         S_HOLD: begin
            // [R23] scl stays low while flag set, except after arbitration loss (0x38), where it is released
            if (!r.control[CTL_DONE] && !(WR_I && ADDR_I == ADDR_CONTROL)) begin
               if (!r.control[CTL_ENABLE]) begin
                  next_r.scl_oe = 1'b0;
                  next_r.sda_oe = 1'b0;
                  next_r.owned = 1'b0;
                  next_r.status = ST_IDLE;
                  next_r.state = S_IDLE;
               end else if (r.status == ST_ARB_LOST) begin
                  // [R20] [R21] release, optionally retry
                  next_r.owned = 1'b0;
                  next_r.status = ST_IDLE;
                  next_r.state = r.control[CTL_START] ? S_WAIT_FREE : S_IDLE;
               end else if (r.control[CTL_STOP]) begin
                  // [R13] [R18] stop first
                  next_r.sda_oe = 1'b1;
                  next_r.state = S_STOP_A;
               end else if (r.control[CTL_START] && r.status != ST_START && r.status != ST_RSTART) begin
                  // [R15] repeated start, bus kept
                  next_r.sda_oe = 1'b0;
                  next_r.restart_after_stop = 1'b1;
                  next_r.state = S_RS_A;
               end else begin
                  // [R11] [R17] send loaded byte
                  next_r.addr_phase = (r.status == ST_START || r.status == ST_RSTART);
                  next_r.shift = r.data;
                  next_r.bit_cnt = 4'h0;
                  next_r.sda_oe = ~r.data[7];
                  next_r.state = S_BIT_LOW;
               end
            end
         end
         S_BIT_LOW: begin
            // sda moves a cycle after scl falls, never beside it, so no false start or stop
            next_r.sda_oe = (r.bit_cnt == 4'h8) ? 1'b0 : ~r.shift[7];
            if (tick) begin
               next_r.scl_oe = 1'b0;
               next_r.state = S_BIT_HIGH;
            end
         end
         S_BIT_HIGH: begin
            // wait for scl high so a stretching target is honoured
            if (tick && line.scl) begin
               next_r.scl_oe = 1'b1;
               if (r.bit_cnt == 4'h8) begin
                  next_r.sda_oe = 1'b0;
                  next_r.control[CTL_DONE] = 1'b1;
                  // [R7] [R10] ack status
                  if (r.addr_phase) begin
                     next_r.status = line.sda ? ST_ADDR_NACK : ST_ADDR_ACK;
                     next_r.rx_mode = r.shift[7];
                  end else begin
                     next_r.status = line.sda ? ST_DATA_NACK : ST_DATA_ACK;
                  end
                  next_r.state = S_HOLD;
               end else if (!r.sda_oe && !line.sda) begin
                  // [R19] arbitration lost
                  next_r.scl_oe = 1'b0;
                  next_r.sda_oe = 1'b0;
                  next_r.status = ST_ARB_LOST;
                  next_r.control[CTL_DONE] = 1'b1;
                  next_r.state = S_HOLD;
               end else begin
                  next_r.bit_cnt = r.bit_cnt + 4'h1;
                  next_r.shift = (r.bit_cnt == 4'h7) ? r.shift : {r.shift[6:0], 1'b0};
                  next_r.state = S_BIT_LOW;
               end
            end
         end
         S_RS_A: begin
            if (tick) begin
               next_r.scl_oe = 1'b0;
               next_r.state = S_WAIT_FREE;
            end
         end
         S_STOP_A: begin
            if (tick) begin
               next_r.scl_oe = 1'b0;
               next_r.state = S_STOP_B;
            end
         end
         S_STOP_B: begin
            if (tick && line.scl) begin
               next_r.sda_oe = 1'b0;
               next_r.state = S_STOP_C;
            end
         end
         S_STOP_C: begin
            next_r.control[CTL_STOP] = 1'b0;
            next_r.owned = 1'b0;
            next_r.status = ST_IDLE;
            next_r.state = r.control[CTL_START] ? S_WAIT_FREE : S_IDLE;
         end
      endcase
      // [R24] request follows flag
      next_r.irq = next_r.control[CTL_DONE] && next_r.control[CTL_IRQEN];
   end

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         r <= '{state: S_IDLE, control: CONTROL_RESET, status: ST_IDLE, data: DATA_RESET, shift: 8'h00,
                bit_cnt: 4'h0, addr_phase: 1'b0, restart_after_stop: 1'b0, owned: 1'b0, scl_oe: 1'b0,
                sda_oe: 1'b0, rdata: 8'h00, rx_mode: 1'b0, irq: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign RDATA_O = r.rdata;
   assign SCL_O = 1'b0;
   assign SDA_O = 1'b0;
   assign SCL_OE_O = r.scl_oe;
   assign SDA_OE_O = r.sda_oe;
   assign RECEIVE_MODE_O = r.rx_mode;
   assign IRQ_O = r.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_COLLISION: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R9]
      (WR_I && ADDR_I == ADDR_DATA && !r.control[CTL_DONE]) |=> (r.control[CTL_WCOL] && $stable(r.data)))
      else $error("data write with flag low not dropped");
   AST_CLEAR: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R6]
      (WR_I && ADDR_I == ADDR_CONTROL && !WDATA_I[CTL_DONE] && r.control[CTL_DONE] && r.state == S_HOLD)
      |=> r.control[CTL_DONE])
      else $error("writing zero changed done flag");
   AST_HOLD_LOW: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R23]
      (r.state == S_HOLD && r.status != ST_ARB_LOST) |-> r.scl_oe)
      else $error("scl released while suspended");
   AST_START_CODE: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R4]
      (r.state == S_START_B && !r.restart_after_stop) |=> (r.status == ST_START && r.control[CTL_DONE]))
      else $error("start status wrong");
   AST_IDLE_WAIT: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R3]
      (r.state == S_WAIT_FREE && line.bus_busy && !r.owned) |=> !r.sda_oe)
      else $error("start driven on busy bus");
   AST_STOP_SELF: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R13]
      (r.state == S_STOP_C) |=> (!r.control[CTL_STOP] && !r.owned))
      else $error("stop request not self cleared");
   AST_IRQ: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R24]
      IRQ_O |-> $past(r.control[CTL_DONE]) || r.control[CTL_DONE])
      else $error("irq without done flag");
   AST_ARB: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R19]
      (r.state == S_BIT_HIGH && tick && line.scl && r.bit_cnt != 4'h8 && !r.sda_oe && !line.sda)
      |=> (r.status == ST_ARB_LOST && r.control[CTL_DONE] && !r.scl_oe))
      else $error("arbitration loss not reported");
   AST_ENABLE: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I) // [R1]
      (r.state == S_IDLE && !r.control[CTL_ENABLE]) |=> (r.state == S_IDLE))
      else $error("activity with interface disabled");
endmodule
`default_nettype wire

// >>> logic/i2cmt_line_if.sv
// interface: synchronised bus lines and bus-free indication between modules.
// assumes both ends on CLK_SYS_I.
`timescale 1ns/10ps
`default_nettype none
interface i2cmt_line_if;
   logic scl;
   logic sda;
   logic bus_busy;
   modport mon (output scl, output sda, output bus_busy);
   modport ctl (input scl, input sda, input bus_busy);
endinterface
`default_nettype wire

// >>> logic/i2cmt_pkg.sv
// package: register map, control bit positions, status codes and timing for
// the two-wire controller-transmitter. assumes 8-bit registers on a plain port.
package i2cmt_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [1:0] ADDR_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_DATA = 2'h2;
   // ----------------------------------------------------------------
   // twowire_control bit positions
   // ----------------------------------------------------------------
   localparam int CTL_DONE = 7;
   localparam int CTL_ACKEN = 6;
   localparam int CTL_START = 5;
   localparam int CTL_STOP = 4;
   localparam int CTL_WCOL = 3;
   localparam int CTL_ENABLE = 2;
   localparam int CTL_IRQEN = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'hff;
   // ----------------------------------------------------------------
   // status codes, prescaler bits zero
   // ----------------------------------------------------------------
   localparam logic [7:0] ST_START = 8'h08;
   localparam logic [7:0] ST_RSTART = 8'h10;
   localparam logic [7:0] ST_ADDR_ACK = 8'h18;
   localparam logic [7:0] ST_ADDR_NACK = 8'h20;
   localparam logic [7:0] ST_DATA_ACK = 8'h28;
   localparam logic [7:0] ST_DATA_NACK = 8'h30;
   localparam logic [7:0] ST_ARB_LOST = 8'h38;
   localparam logic [7:0] ST_IDLE = 8'hf8;
   localparam logic [7:0] STATUS_MASK = 8'hf8;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int HALF_BIT_NS = 2500;
   localparam int HALF_BIT_CYCLES = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUS_FREE_NS = 4700;
   localparam int BUS_FREE_CYCLES = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIT_COUNT_RESET = 0;
endpackage

// >>> verif/i2c_master_transmit_ctrl_tb_top.sv
// testbench: register-port sequences for start, bytes, restart, stop and lost
// arbitration. assumes pull-ups on both lines and the target model.
`timescale 1ns/10ps
`default_nettype none
module i2c_master_transmit_ctrl_tb_top
   import i2cmt_pkg::*;
();
   localparam int HALF = 4;
   logic clk, rst_n, wr, rd, tnack, fsda, fscl;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, tbyte;
   logic scl_o, scl_oe, sda_o, sda_oe, tsda_oe, recv, irq;
   int fails, checks, tstarts, tstops;
   wire scl_ln = !(scl_oe | fscl);
   wire sda_ln = !(sda_oe | tsda_oe | fsda);
   i2cmt_ctrl #(.HALF_CYCLES(HALF)) dut_u (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SCL_I(scl_ln), .SCL_O(scl_o),
      .SCL_OE_O(scl_oe), .SDA_I(sda_ln), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
      .RECEIVE_MODE_O(recv), .IRQ_O(irq));
   i2cmt_target_model tgt_u (.scl_i(scl_ln), .sda_i(sda_ln), .nack_i(tnack), .sda_oe_o(tsda_oe),
      .byte_o(tbyte), .starts_o(tstarts), .stops_o(tstops));
   // ----
   // shared tasks
   // ----
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t %s: %h not %h", $time, msg, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (fails == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk_reg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
      logic [7:0] d;
      rd_reg(a, d);
      check(d & m, e, s);
   endtask
   task automatic wait_reg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      for (int i = 0; i < 3000; i++) begin
         rd_reg(a, d);
         if ((d & m) === e) return;
      end
      fails++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
   endtask
   // one software step: control write, wait for the flag, status compare
   task automatic step(input logic [7:0] ctl, input logic [7:0] st);
      wr_reg(ADDR_CONTROL, ctl);
      wait_reg(ADDR_CONTROL, 8'h80, 8'h80);
      chk_reg(ADDR_STATUS, STATUS_MASK, st, "status");
   endtask
   task automatic send(input logic [7:0] b, input logic [7:0] st);
      wr_reg(ADDR_DATA, b);
      step(8'h84, st);
   endtask
   task automatic quiet(input int n);
      logic d;
      d = 1'b0;
      repeat (n) begin
         @(posedge clk);
         d = d | sda_oe | scl_oe;
      end
      check({7'h0, d}, 8'h00, "bus driven");
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset();
      chk_reg(ADDR_CONTROL, 8'hff, CONTROL_RESET, "control");
      chk_reg(ADDR_STATUS, 8'hff, ST_IDLE, "status");
      chk_reg(ADDR_DATA, 8'hff, DATA_RESET, "data");
      chk_reg(2'h3, 8'hff, 8'h00, "unmapped");
      wr_reg(ADDR_CONTROL, 8'ha0);
      quiet(BUS_FREE_CYCLES + 4 * HALF);
   endtask
   task automatic t_write();
      step(8'ha5, ST_START);
      check(8'(tstarts), 8'h01, "starts");
      check({7'h0, irq}, 8'h01, "irq");
      wr_reg(ADDR_DATA, 8'ha0);
      wr_reg(ADDR_CONTROL, 8'h05);
      chk_reg(ADDR_CONTROL, 8'h80, 8'h80, "flag");
      check({7'h0, scl_oe}, 8'h01, "stretch");
      wr_reg(ADDR_CONTROL, 8'h85);
      wr_reg(ADDR_DATA, 8'h55);
      check({7'h0, irq}, 8'h00, "irq");
      wait_reg(ADDR_CONTROL, 8'h80, 8'h80);
      chk_reg(ADDR_STATUS, STATUS_MASK, ST_ADDR_ACK, "status");
      check(tbyte, 8'ha0, "address");
      chk_reg(ADDR_CONTROL, 8'h08, 8'h08, "collision");
      send(8'h3c, ST_DATA_ACK);
      check(tbyte, 8'h3c, "data");
      tnack <= 1'b1;
      send(8'hc3, ST_DATA_NACK);
      check(tbyte, 8'hc3, "data");
   endtask
   task automatic t_restart();
      step(8'ha4, ST_RSTART);
      check(8'(tstops), 8'h00, "stops");
      send(8'ha2, ST_ADDR_NACK);
      tnack <= 1'b0;
      wr_reg(ADDR_CONTROL, 8'h94);
      wait_reg(ADDR_STATUS, 8'hff, ST_IDLE);
      check(8'(tstops), 8'h01, "stops");
      chk_reg(ADDR_CONTROL, 8'h10, 8'h00, "stop bit");
      step(8'ha4, ST_START);
      send(8'ha2, ST_ADDR_ACK);
      step(8'hb4, ST_START);
      check(8'(tstops), 8'h02, "stops");
      chk_reg(ADDR_CONTROL, 8'h10, 8'h00, "stop bit");
      send(8'ha0, ST_ADDR_ACK);
      step(8'ha4, ST_RSTART);
      wr_reg(ADDR_DATA, 8'ha1);
      wr_reg(ADDR_CONTROL, 8'h84);
      wait_reg(ADDR_CONTROL, 8'h80, 8'h80);
      check(tbyte, 8'ha1, "address");
      check({7'h0, recv}, 8'h01, "receive");
      rst_n <= 1'b0;
      @(posedge clk);
      check({4'h0, recv, irq, sda_oe, scl_oe}, 8'h00, "reset");
      rst_n <= 1'b1;
   endtask
   // a foreign low on sda while a one is sent costs the arbitration
   task automatic lose();
      step(8'ha4, ST_START);
      wr_reg(ADDR_DATA, 8'h80);
      fsda <= 1'b1;
      step(8'h84, ST_ARB_LOST);
      fsda <= 1'b0;
   endtask
   task automatic t_arb();
      lose();
      wr_reg(ADDR_CONTROL, 8'h84);
      wait_reg(ADDR_STATUS, 8'hff, ST_IDLE);
      quiet(4 * HALF);
      lose();
      fsda <= 1'b1;
      wr_reg(ADDR_CONTROL, 8'ha4);
      // foreign frame on its own 125 ns clock
      repeat (6) begin
         fscl = 1'b1;
         #62.5 fscl = 1'b0;
         #62.5;
      end
      quiet(BUS_FREE_CYCLES + 4 * HALF);
      fsda <= 1'b0;
      wait_reg(ADDR_CONTROL, 8'h80, 8'h80);
      chk_reg(ADDR_STATUS, STATUS_MASK, ST_START, "status");
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      tnack = 1'b0;
      fsda = 1'b0;
      fscl = 1'b0;
      fails = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_write();
      t_restart();
      t_arb();
      report_and_stop();
   end
endmodule
`default_nettype wire

// >>> verif/i2cmt_target_model.sv
// target receiver model: takes bytes msb first, acks or nacks on demand,
// counts START and STOP. assumes pulled-up lines resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
module i2cmt_target_model (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic nack_i,
   output logic sda_oe_o,
   output logic [7:0] byte_o,
   output int starts_o,
   output int stops_o
);
   logic [7:0] sh;
   int bits;
   logic armed;
   // lines leave the unknown state at time zero; those edges are no framing
   initial begin
      armed = 1'b0;
      #1 armed = 1'b1;
   end
   initial begin
      sda_oe_o = 1'b0;
      byte_o = 8'h00;
      sh = 8'h00;
      bits = 0;
      starts_o = 0;
      stops_o = 0;
   end
   // ----
   // framing seen as sda edges while scl is high
   // ----
   always @(negedge sda_i) begin
      if (armed && scl_i === 1'b1) begin
         starts_o++;
         bits = 0;
      end
   end
   always @(posedge sda_i) begin
      if (armed && scl_i === 1'b1) begin
         stops_o++;
         bits = 0;
      end
   end
   always @(posedge scl_i) begin
      if (bits < 8) begin
         sh = {sh[6:0], sda_i};
         bits++;
         if (bits == 8) begin
            byte_o = sh;
         end
      end
   end
   // acknowledge held from the eighth scl fall to the ninth, then released
   always @(negedge scl_i) begin
      if (bits == 8) begin
         sda_oe_o <= !nack_i;
         bits = 9;
      end else if (bits == 9) begin
         sda_oe_o <= 1'b0;
         bits = 0;
      end
   end
endmodule
`default_nettype wire
